// ---- common/tlr_pkg.sv ----
package tlr_pkg;
  localparam int CLK_NS = 8;
  localparam int BYTE_NS = 50;
  localparam int BYTE_CYC = (BYTE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTORE_NS = 80;
  localparam int RESTORE_CYC = RESTORE_NS / CLK_NS;
  localparam int CONT_NS = 100;
  localparam int CONT_CYC = CONT_NS / CLK_NS;
  localparam int SYNC_LAT = 3;
  localparam int LINK_LINES = 12;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_PORTS = 6;
  localparam int DEFAULT_HOLDERS = 3;
  localparam int MAX_CARDS = 3;
  localparam int WAIT_MIN = 1;
  localparam int WAIT_MAX = 3;
  localparam int WAIT_DEF = 2;
  localparam int CNT_W = 4;
  localparam int SYNC_W = DATA_W + 7;
  localparam int SB_STR = 8;
  localparam int SB_RDY = 9;
  localparam int SB_TREQ = 10;
  localparam int SB_TACK = 11;
  localparam int SB_TRST = 12;
  localparam int SB_AUX = 13;
  localparam int SB_INT = 14;
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7000;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hff;
  typedef enum logic [2:0] {
    ST_RESTORE = 3'b000,
    ST_IN = 3'b001,
    ST_HOLD = 3'b010,
    ST_STROBE = 3'b011,
    ST_GIVE = 3'b100
  } tlr_link_st_t;
endpackage

// ---- common/tlr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tlr_link_if;
  import tlr_pkg::*;
  logic [DATA_W-1:0] dev_d_o, peer_d_o, data;
  logic dev_d_oe, peer_d_oe, dev_str, peer_str, dev_rdy, peer_rdy;
  logic dev_treq, peer_treq, dev_tack, peer_tack;
  logic dev_trst_oe, peer_trst_oe, dev_aux_oe, peer_aux_oe, dev_int_oe, peer_int_oe;
  logic token_restore_n, aux_link_reset_n, link_interrupt_n, contention;
  // Wire resolution; open-drain lines pulled high
  assign data = dev_d_oe ? dev_d_o : (peer_d_oe ? peer_d_o : BUS_IDLE);
  assign contention = dev_d_oe && peer_d_oe;
  assign token_restore_n = !(dev_trst_oe || peer_trst_oe);
  assign aux_link_reset_n = !(dev_aux_oe || peer_aux_oe);
  assign link_interrupt_n = !(dev_int_oe || peer_int_oe);
  modport dev (
    output dev_d_o, dev_d_oe, dev_str, dev_rdy, dev_treq, dev_tack,
    output dev_trst_oe, dev_aux_oe, dev_int_oe,
    input data, peer_str, peer_rdy, peer_treq, peer_tack,
    input token_restore_n, aux_link_reset_n, link_interrupt_n
  );
  modport peer (
    output peer_d_o, peer_d_oe, peer_str, peer_rdy, peer_treq, peer_tack,
    output peer_trst_oe, peer_aux_oe, peer_int_oe,
    input data, dev_str, dev_rdy, dev_treq, dev_tack,
    input token_restore_n, aux_link_reset_n, link_interrupt_n
  );
endinterface
`default_nettype wire

// ---- verilog/tlr_dev_end.sv ----
// Functional notes
// R1: Link has eight data, strobe, ready, token, ack.
// R2: Drive data only while holding the token.
// R3: Three of six ports start holding token.
// R4: Ends pass token back and forth.
// R5: Reset port retakes token at its default.
// R6: Outside logic limits contention to 100 ns.
// R7: Up to 20 MB/s, own DMA per link.
// R8: Any node reset resets whole network.
// R9: Token restore resets all links, raises NMI.
// R10: Software chooses reset or continue after NMI.
// R11: Aux reset and interrupt leave tokens alone.
// R12: Remote aux reset or interrupt interrupts node.
// R13: Interrupt input and direction-configurable reset line.
// R14: Global memory alternates host and processor cycles.
// R15: Host expansion traffic never stalls processor SRAM.
// R16: Expansion bus takes at most three cards.
// R17: Expansion memory answers with one to three waits.
// R18: Spare links keep each link one-way.
// R19: Drive token restore before any strobe after reset.
`timescale 1ns/1ps
`default_nettype none

module tlr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import tlr_pkg::*;
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tlr_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    logic in_rdy, out_vld;
  } tlr_fifo_st_t;
  tlr_fifo_st_t s_r, s_nxt;
  logic push, pop;
  assign push = in_valid && s_r.in_rdy;
  assign pop = out_ready && s_r.out_vld;
  assign in_ready = s_r.in_rdy;
  assign out_valid = s_r.out_vld;
  assign out_data = s_r.mem[s_r.rp];
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    s_nxt.in_rdy = s_nxt.cnt != (AW+1)'(DEPTH);
    s_nxt.out_vld = s_nxt.cnt != '0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.in_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // tlr_fifo

module tlr_link_core #(
  parameter bit HOLD_DEFAULT = 1'b1,
  parameter bit ALLOW_REQ = 1'b1,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic sw_reset,
  input wire logic aux_dir_out,
  input wire logic aux_req,
  input wire logic int_req,
  output logic holds_token,
  output logic nmi,
  output logic remote_irq,
  input wire logic [7:0] d_i,
  input wire logic str_i,
  input wire logic rdy_i,
  input wire logic treq_i,
  input wire logic tack_i,
  input wire logic trst_n_i,
  input wire logic aux_n_i,
  input wire logic int_n_i,
  output logic [7:0] d_o,
  output logic d_oe,
  output logic str_o,
  output logic rdy_o,
  output logic treq_o,
  output logic tack_o,
  output logic trst_oe,
  output logic aux_oe,
  output logic int_oe
);
  import tlr_pkg::*;
  typedef struct packed {
    tlr_link_st_t st;
    logic tok, drv;
    logic [CNT_W-1:0] cnt, gap;
    logic [DATA_W-1:0] d_o, rx_data;
    logic d_oe, str, rdy, treq, tack, trst_oe, nmi, rx_valid, irq, aux_oe, int_oe;
    logic [SYNC_W-1:0] s1, s2;
    logic [2:0] prev;
  } tlr_core_st_t;
  tlr_core_st_t s_r, s_nxt;
  logic [DATA_W-1:0] f_data;
  logic f_valid, pop, trst_fall;
  // Byte queue stands in for the per-link DMA channel
  tlr_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_txq ( // see R7
    .clk(clk),
    .rst_n(rst_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(pop)
  );
  // Peer request wins over a new byte to keep traffic fair
  assign pop = s_r.st == ST_HOLD && !s_r.s2[SB_TREQ] && s_r.gap == '0 && f_valid;
  assign trst_fall = s_r.prev[0] && !s_r.s2[SB_TRST];
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = {int_n_i, aux_n_i, trst_n_i, tack_i, treq_i, rdy_i, str_i, d_i}; // see R1
    s_nxt.s2 = s_r.s1;
    s_nxt.prev = {s_r.s2[SB_INT], s_r.s2[SB_AUX], s_r.s2[SB_TRST]};
    s_nxt.nmi = 1'b0;
    s_nxt.irq = 1'b0;
    if (s_r.gap != '0) begin
      s_nxt.gap = s_r.gap - 1'b1;
    end
    if (s_r.rx_valid && rx_ready) begin
      s_nxt.rx_valid = 1'b0;
    end
    s_nxt.aux_oe = aux_dir_out && aux_req; // see R13
    s_nxt.int_oe = int_req;
    // Remote aux reset and interrupt only raise an event, tokens untouched
    if ((s_r.prev[1] && !s_r.s2[SB_AUX] && !aux_dir_out) ||
        (s_r.prev[2] && !s_r.s2[SB_INT])) begin
      s_nxt.irq = 1'b1; // see R11 see R12
    end
    case (s_r.st)
      ST_RESTORE: begin
        if (s_r.drv) begin
          if (s_r.cnt == '0) begin
            s_nxt.drv = 1'b0;
          end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
          end
        end else if (s_r.s2[SB_TRST]) begin
          s_nxt.st = s_r.tok ? ST_HOLD : ST_IN; // see R19
        end
      end
      ST_IN: begin
        if (s_r.s2[SB_STR] && !s_r.rdy && !s_r.rx_valid) begin
          s_nxt.rx_data = s_r.s2[DATA_W-1:0];
          s_nxt.rx_valid = 1'b1;
          s_nxt.rdy = 1'b1;
        end else if (s_r.rdy && !s_r.s2[SB_STR]) begin
          s_nxt.rdy = 1'b0;
        end
        s_nxt.treq = ALLOW_REQ && f_valid; // see R18
        if (s_r.treq && s_r.s2[SB_TACK]) begin
          s_nxt.treq = 1'b0;
          s_nxt.tok = 1'b1; // see R4
          s_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (s_r.s2[SB_TREQ]) begin
          s_nxt.tok = 1'b0; // see R4
          s_nxt.st = ST_GIVE;
        end else if (pop) begin
          s_nxt.d_o = f_data;
          s_nxt.str = 1'b1;
          s_nxt.gap = CNT_W'(BYTE_CYC); // see R7
          s_nxt.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (s_r.str && s_r.s2[SB_RDY]) begin
          s_nxt.str = 1'b0;
        end else if (!s_r.str && !s_r.s2[SB_RDY]) begin
          s_nxt.st = ST_HOLD;
        end
      end
      ST_GIVE: begin
        // Ack goes out only after our drivers are already off
        s_nxt.tack = 1'b1;
        if (s_r.tack && !s_r.s2[SB_TREQ]) begin
          s_nxt.tack = 1'b0;
          s_nxt.st = ST_IN;
        end
      end
      default: begin
        s_nxt.st = ST_RESTORE;
      end
    endcase
    if (sw_reset || (trst_fall && !s_r.drv)) begin
      s_nxt.st = ST_RESTORE;
      s_nxt.tok = HOLD_DEFAULT; // see R5 see R9
      s_nxt.str = 1'b0;
      s_nxt.rdy = 1'b0;
      s_nxt.treq = 1'b0;
      s_nxt.tack = 1'b0;
      s_nxt.nmi = !sw_reset; // see R9
      if (sw_reset) begin
        s_nxt.drv = 1'b1; // see R10
        s_nxt.cnt = CNT_W'(RESTORE_CYC);
      end
    end
    s_nxt.trst_oe = s_nxt.drv; // see R19
    s_nxt.d_oe = s_nxt.tok && (s_nxt.st == ST_HOLD || s_nxt.st == ST_STROBE); // see R2
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= ST_RESTORE;
      s_r.tok <= HOLD_DEFAULT; // see R5
      s_r.drv <= 1'b1;
      s_r.cnt <= CNT_W'(RESTORE_CYC);
      s_r.trst_oe <= 1'b1;
      s_r.s1 <= SYNC_RST;
      s_r.s2 <= SYNC_RST;
      s_r.prev <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign holds_token = s_r.tok;
  assign nmi = s_r.nmi;
  assign remote_irq = s_r.irq;
  assign d_o = s_r.d_o;
  assign d_oe = s_r.d_oe;
  assign str_o = s_r.str;
  assign rdy_o = s_r.rdy;
  assign treq_o = s_r.treq;
  assign tack_o = s_r.tack;
  assign trst_oe = s_r.trst_oe;
  assign aux_oe = s_r.aux_oe;
  assign int_oe = s_r.int_oe;
endmodule // tlr_link_core

module tlr_dev_end #(
  parameter int PORT_INDEX = 0,
  parameter int DEPTH = tlr_pkg::FIFO_DEPTH,
  parameter int WAIT_ST = tlr_pkg::WAIT_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  tlr_link_if.dev LNK,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  input wire logic SW_RESET,
  input wire logic AUX_DIR_OUT,
  input wire logic AUX_RESET_REQ,
  input wire logic LINK_INT_REQ,
  output logic HOLDS_TOKEN,
  output logic NMI,
  output logic REMOTE_IRQ,
  input wire logic HOST_REQ,
  input wire logic HOST_EXP,
  input wire logic [1:0] HOST_CARD,
  input wire logic PROC_REQ,
  output logic HOST_GNT,
  output logic PROC_GNT,
  output logic HOST_ERR,
  output logic EXP_ACK
);
  import tlr_pkg::*;
  if (PORT_INDEX < 0 || PORT_INDEX >= NUM_PORTS) begin : g_bad_port
    $error("tlr_dev_end port index out of range");
  end
  if (WAIT_ST < WAIT_MIN || WAIT_ST > WAIT_MAX) begin : g_bad_wait
    $error("tlr_dev_end wait states out of range");
  end
  localparam bit HOLD_DEF = PORT_INDEX < DEFAULT_HOLDERS; // see R3
  tlr_link_core #(.HOLD_DEFAULT(HOLD_DEF), .ALLOW_REQ(1'b1), .DEPTH(DEPTH)) u_core (
    .clk(CLK),
    .rst_n(RESETN),
    .tx_data(TX_DATA),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY),
    .rx_data(RX_DATA),
    .rx_valid(RX_VALID),
    .rx_ready(RX_READY),
    .sw_reset(SW_RESET),
    .aux_dir_out(AUX_DIR_OUT),
    .aux_req(AUX_RESET_REQ),
    .int_req(LINK_INT_REQ),
    .holds_token(HOLDS_TOKEN),
    .nmi(NMI),
    .remote_irq(REMOTE_IRQ),
    .d_i(LNK.data),
    .str_i(LNK.peer_str),
    .rdy_i(LNK.peer_rdy),
    .treq_i(LNK.peer_treq),
    .tack_i(LNK.peer_tack),
    .trst_n_i(LNK.token_restore_n),
    .aux_n_i(LNK.aux_link_reset_n),
    .int_n_i(LNK.link_interrupt_n),
    .d_o(LNK.dev_d_o),
    .d_oe(LNK.dev_d_oe),
    .str_o(LNK.dev_str),
    .rdy_o(LNK.dev_rdy),
    .treq_o(LNK.dev_treq),
    .tack_o(LNK.dev_tack),
    .trst_oe(LNK.dev_trst_oe),
    .aux_oe(LNK.dev_aux_oe),
    .int_oe(LNK.dev_int_oe)
  );
  typedef struct packed {
    logic last_host, hgnt, pgnt, err, ack;
    logic [1:0] wcnt;
  } tlr_gbus_st_t;
  tlr_gbus_st_t g_r, g_nxt;
  logic host_ok, conflict;
  assign host_ok = !HOST_EXP || HOST_CARD < 2'(MAX_CARDS); // see R16
  assign conflict = HOST_REQ && !HOST_EXP && PROC_REQ;
  always_comb begin
    g_nxt = g_r;
    g_nxt.ack = 1'b0;
    g_nxt.err = HOST_REQ && !host_ok;
    // Expansion traffic goes through buffers, so processor is never held
    g_nxt.pgnt = PROC_REQ && !(conflict && !g_r.last_host); // see R14 see R15
    g_nxt.hgnt = HOST_REQ && host_ok && !(conflict && g_r.last_host) &&
                 !(HOST_EXP && g_r.wcnt != 2'h0); // see R14
    if (conflict) begin
      g_nxt.last_host = !g_r.last_host;
    end
    if (g_r.wcnt != 2'h0) begin
      g_nxt.wcnt = g_r.wcnt - 1'b1;
      g_nxt.ack = g_r.wcnt == 2'h1;
    end else if (g_nxt.hgnt && HOST_EXP) begin
      g_nxt.wcnt = 2'(WAIT_ST); // see R17
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end
  assign HOST_GNT = g_r.hgnt;
  assign PROC_GNT = g_r.pgnt;
  assign HOST_ERR = g_r.err;
  assign EXP_ACK = g_r.ack;
endmodule // tlr_dev_end
`default_nettype wire

// ---- verilog/tlr_peer_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlr_peer_end #(
  parameter bit HOLD_DEF = 1'b0,
  parameter bit ONE_WAY = 1'b0,
  parameter int DEPTH = tlr_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RESETN,
  tlr_link_if.peer LNK,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  input wire logic SW_RESET,
  input wire logic AUX_DIR_OUT,
  input wire logic AUX_RESET_REQ,
  input wire logic LINK_INT_REQ,
  output logic HOLDS_TOKEN,
  output logic NMI,
  output logic REMOTE_IRQ,
  output logic NODE_RESET
);
  import tlr_pkg::*;
  // Restore seen to drivers off must fit the contention budget
  if (SYNC_LAT + 1 > CONT_CYC) begin : g_bad_lat
    $error("tlr_peer_end release latency exceeds contention limit"); // see R6
  end
  logic nmi_w;
  tlr_link_core #(.HOLD_DEFAULT(HOLD_DEF), .ALLOW_REQ(!ONE_WAY), .DEPTH(DEPTH)) u_core (
    .clk(CLK),
    .rst_n(RESETN),
    .tx_data(TX_DATA),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY),
    .rx_data(RX_DATA),
    .rx_valid(RX_VALID),
    .rx_ready(RX_READY),
    .sw_reset(SW_RESET),
    .aux_dir_out(AUX_DIR_OUT),
    .aux_req(AUX_RESET_REQ),
    .int_req(LINK_INT_REQ),
    .holds_token(HOLDS_TOKEN),
    .nmi(nmi_w),
    .remote_irq(REMOTE_IRQ),
    .d_i(LNK.data),
    .str_i(LNK.dev_str),
    .rdy_i(LNK.dev_rdy),
    .treq_i(LNK.dev_treq),
    .tack_i(LNK.dev_tack),
    .trst_n_i(LNK.token_restore_n),
    .aux_n_i(LNK.aux_link_reset_n),
    .int_n_i(LNK.link_interrupt_n),
    .d_o(LNK.peer_d_o),
    .d_oe(LNK.peer_d_oe),
    .str_o(LNK.peer_str),
    .rdy_o(LNK.peer_rdy),
    .treq_o(LNK.peer_treq),
    .tack_o(LNK.peer_tack),
    .trst_oe(LNK.peer_trst_oe),
    .aux_oe(LNK.peer_aux_oe),
    .int_oe(LNK.peer_int_oe)
  );
  typedef struct packed {
    logic nmi, node_rst;
  } tlr_peer_st_t;
  tlr_peer_st_t p_r, p_nxt;
  always_comb begin
    p_nxt = p_r;
    p_nxt.nmi = nmi_w;
    // A two-way link cannot survive a lone reset, so pass it on
    p_nxt.node_rst = nmi_w && !ONE_WAY; // see R8 see R18
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      p_r <= '0;
    end else begin
      p_r <= p_nxt;
    end
  end
  assign NMI = p_r.nmi;
  assign NODE_RESET = p_r.node_rst;
endmodule // tlr_peer_end
`default_nettype wire

// ---- testbench/tlr_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlr_link_sva import tlr_pkg::*; (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [DATA_W-1:0] dev_d_o,
  input wire logic dev_d_oe,
  input wire logic peer_d_oe,
  input wire logic dev_str,
  input wire logic peer_str,
  input wire logic peer_rdy,
  input wire logic dev_tack,
  input wire logic peer_treq,
  input wire logic token_restore_n,
  input wire logic aux_link_reset_n,
  input wire logic contention
);
  import tlr_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // Twelve cycles is 96 ns, just inside the damage limit
  a_contention_short: assert property (contention |-> ##[1:12] !contention)
    else $error("both ends drive the data lines too long");
  a_restore_quiet: assert property (!token_restore_n |-> !dev_str && !peer_str)
    else $error("strobe while token restore is low");
  a_restore_release: assert property ($fell(token_restore_n) |-> ##[0:4] !dev_d_oe)
    else $error("data still driven after token restore");
  a_strobe_drives: assert property (dev_str |-> dev_d_oe)
    else $error("strobe without driving the data lines");
  a_data_steady: assert property (dev_str && $past(dev_str) |-> $stable(dev_d_o))
    else $error("data moved under the strobe");
  a_ready_answers: assert property ($rose(peer_rdy) |-> dev_str)
    else $error("ready raised without a strobe");
  a_byte_rate: assert property ($rose(dev_str) |=> !$rose(dev_str) [*6])
    else $error("strobes closer than the byte period");
  a_token_ack: assert property ($rose(dev_tack) |-> !dev_d_oe)
    else $error("token acknowledged while still driving");
  a_token_answer: assert property ($rose(peer_treq) |-> ##[1:40] dev_tack)
    else $error("token request not answered");
  // Remote event lands three cycles after the fall, so watch past it
  a_aux_token_kept: assert property ($fell(aux_link_reset_n) |=>
    ($stable(dev_d_oe) && $stable(peer_d_oe)) [*6])
    else $error("aux reset disturbed the token");
  c_byte: cover property ($rose(peer_rdy));
  c_pass: cover property ($rose(dev_tack));
  c_restore: cover property ($fell(token_restore_n));
  c_aux: cover property ($fell(aux_link_reset_n));
endmodule // tlr_link_sva
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tlr_pkg::*;
  logic clk, rst_n;
  logic [7:0] d_tx_data, p_tx_data, d_rx_data, p_rx_data;
  logic d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, d_sw, d_aux_dir, d_aux_req, d_int_req;
  logic p_tx_valid, p_tx_ready, p_rx_valid, p_rx_ready, p_sw, p_aux_dir, p_aux_req, p_int_req;
  logic d_tok, d_nmi, d_irq, p_tok, p_nmi, p_irq, p_node_rst;
  logic host_req, host_exp, proc_req, host_gnt, proc_gnt, host_err, exp_ack;
  logic [1:0] host_card;
  int n_fail, comparisons, cnt;
  tlr_link_if tlr_link_if_i ();
  tlr_dev_end tlr_dev_end_i (.CLK(clk), .RESETN(rst_n), .LNK(tlr_link_if_i.dev),
    .TX_DATA(d_tx_data), .TX_VALID(d_tx_valid), .TX_READY(d_tx_ready), .RX_DATA(d_rx_data),
    .RX_VALID(d_rx_valid), .RX_READY(d_rx_ready), .SW_RESET(d_sw), .AUX_DIR_OUT(d_aux_dir),
    .AUX_RESET_REQ(d_aux_req), .LINK_INT_REQ(d_int_req), .HOLDS_TOKEN(d_tok), .NMI(d_nmi),
    .REMOTE_IRQ(d_irq), .HOST_REQ(host_req), .HOST_EXP(host_exp), .HOST_CARD(host_card),
    .PROC_REQ(proc_req), .HOST_GNT(host_gnt), .PROC_GNT(proc_gnt), .HOST_ERR(host_err),
    .EXP_ACK(exp_ack));
  tlr_peer_end tlr_peer_end_i (.CLK(clk), .RESETN(rst_n), .LNK(tlr_link_if_i.peer),
    .TX_DATA(p_tx_data), .TX_VALID(p_tx_valid), .TX_READY(p_tx_ready), .RX_DATA(p_rx_data),
    .RX_VALID(p_rx_valid), .RX_READY(p_rx_ready), .SW_RESET(p_sw), .AUX_DIR_OUT(p_aux_dir),
    .AUX_RESET_REQ(p_aux_req), .LINK_INT_REQ(p_int_req), .HOLDS_TOKEN(p_tok), .NMI(p_nmi),
    .REMOTE_IRQ(p_irq), .NODE_RESET(p_node_rst));
  tlr_link_sva tlr_link_sva_i (.CLK(clk), .RESETN(rst_n), .dev_d_o(tlr_link_if_i.dev_d_o),
    .dev_d_oe(tlr_link_if_i.dev_d_oe), .peer_d_oe(tlr_link_if_i.peer_d_oe),
    .dev_str(tlr_link_if_i.dev_str), .peer_str(tlr_link_if_i.peer_str),
    .peer_rdy(tlr_link_if_i.peer_rdy), .dev_tack(tlr_link_if_i.dev_tack),
    .peer_treq(tlr_link_if_i.peer_treq), .token_restore_n(tlr_link_if_i.token_restore_n),
    .aux_link_reset_n(tlr_link_if_i.aux_link_reset_n), .contention(tlr_link_if_i.contention));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pushes n counting bytes; gives up after max cycles so a full buffer is seen
  task automatic push_dev(input logic [7:0] first, input int n, input int max, output int k);
    logic acc;
    k = 0;
    d_tx_valid = 1'b1;
    for (int g = 0; g < max && k < n; g++) begin
      d_tx_data = first + 8'(k);
      acc = d_tx_ready;
      @(negedge clk);
      if (acc === 1'b1) k++;
    end
    d_tx_valid = 1'b0;
  endtask
  task automatic get_peer(input logic [7:0] exp);
    for (int g = 0; g < 100 && p_rx_valid !== 1'b1; g++) @(negedge clk);
    chk_byte(p_rx_data, exp);
    p_rx_ready = 1'b1;
    @(negedge clk);
    p_rx_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_power_up();
    chk_bit(tlr_link_if_i.token_restore_n, 1'b0);
    repeat (30) @(negedge clk);
    chk_bit(d_tok, 1'b1);
    chk_bit(p_tok, 1'b0);
    chk_bit(tlr_link_if_i.dev_d_oe, 1'b1);
    chk_bit(tlr_link_if_i.peer_d_oe, 1'b0);
    $display("power-up test finished");
  endtask
  task automatic t_dev_to_peer();
    push_dev(8'h5a, 2, 100, cnt);
    get_peer(8'h5a);
    get_peer(8'h5b);
    $display("outbound byte test finished");
  endtask
  task automatic t_peer_to_dev();
    p_tx_data = 8'hc3;
    p_tx_valid = 1'b1;
    for (int g = 0; g < 50 && p_tx_ready !== 1'b1; g++) @(negedge clk);
    @(negedge clk);
    p_tx_valid = 1'b0;
    for (int g = 0; g < 100 && d_rx_valid !== 1'b1; g++) @(negedge clk);
    chk_byte(d_rx_data, 8'hc3);
    chk_bit(p_tok, 1'b1);
    chk_bit(d_tok, 1'b0);
    chk_bit(tlr_link_if_i.dev_d_oe, 1'b0);
    chk_bit(tlr_link_if_i.peer_d_oe, 1'b1);
    d_rx_ready = 1'b1;
    @(negedge clk);
    d_rx_ready = 1'b0;
    $display("token pass test finished");
  endtask
  task automatic t_fill();
    // Receiver stalls, so the buffer must refuse after its depth plus bytes in flight
    push_dev(8'h10, 40, 400, cnt);
    chk_bit(d_tx_ready, 1'b0);
    chk_bit(cnt >= FIFO_DEPTH && cnt <= FIFO_DEPTH + 3, 1'b1);
    for (int k = 0; k < cnt; k++) get_peer(8'h10 + 8'(k));
    chk_bit(d_tx_ready, 1'b1);
    $display("buffer test finished");
  endtask
  task automatic t_restore();
    int nmi_n, node_n;
    nmi_n = 0;
    node_n = 0;
    // Peer finishes its last byte first; a strobe must not overlap restore
    repeat (20) @(negedge clk);
    chk_bit(p_tok, 1'b1);
    d_sw = 1'b1;
    @(negedge clk);
    d_sw = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      nmi_n += int'(p_nmi === 1'b1);
      node_n += int'(p_node_rst === 1'b1);
    end
    chk_bit(nmi_n == 1, 1'b1);
    chk_bit(node_n == 1, 1'b1);
    chk_bit(d_tok, 1'b1);
    chk_bit(p_tok, 1'b0);
    // Restore from the far end: this end takes the NMI and its default token
    nmi_n = 0;
    p_sw = 1'b1;
    @(negedge clk);
    p_sw = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      nmi_n += int'(d_nmi === 1'b1);
      node_n += int'(p_node_rst === 1'b1);
    end
    chk_bit(nmi_n == 1, 1'b1);
    chk_bit(node_n == 1, 1'b1);
    chk_bit(d_tok, 1'b1);
    chk_bit(tlr_link_if_i.dev_d_oe, 1'b1);
    $display("token restore test finished");
  endtask
  task automatic t_aux();
    int irq_n, nmi_n;
    irq_n = 0;
    nmi_n = 0;
    d_aux_req = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(tlr_link_if_i.aux_link_reset_n, 1'b1);
    d_aux_dir = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      irq_n += int'(p_irq === 1'b1);
      nmi_n += int'(p_nmi === 1'b1);
    end
    chk_bit(tlr_link_if_i.aux_link_reset_n, 1'b0);
    d_aux_req = 1'b0;
    p_int_req = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      irq_n += int'(d_irq === 1'b1);
    end
    p_int_req = 1'b0;
    chk_bit(irq_n == 2, 1'b1);
    chk_bit(nmi_n == 0, 1'b1);
    chk_bit(d_tok, 1'b1);
    chk_bit(p_tok, 1'b0);
    $display("aux line test finished");
  endtask
  task automatic t_bus();
    int g0, a0;
    logic pg;
    g0 = -1;
    a0 = -1;
    pg = 1'b0;
    host_req = 1'b1;
    proc_req = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      chk_bit(proc_gnt, (k % 2) == 1);
      chk_bit(host_gnt, (k % 2) == 0);
    end
    host_exp = 1'b1;
    host_card = 2'h3;
    repeat (2) @(negedge clk);
    chk_bit(host_err, 1'b1);
    chk_bit(host_gnt, 1'b0);
    host_card = 2'h1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (host_gnt === 1'b1 && g0 < 0) g0 = i;
      if (exp_ack === 1'b1 && a0 < 0) begin
        a0 = i;
        pg = proc_gnt;
      end
    end
    chk_bit(a0 - g0 >= WAIT_MIN && a0 - g0 <= WAIT_MAX, 1'b1);
    chk_bit(pg, 1'b1);
    host_req = 1'b0;
    proc_req = 1'b0;
    host_exp = 1'b0;
    $display("shared bus test finished");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {d_tx_data, p_tx_data, host_card} = '0;
    {d_tx_valid, d_rx_ready, d_sw, d_aux_dir, d_aux_req, d_int_req} = '0;
    {p_tx_valid, p_rx_ready, p_sw, p_aux_dir, p_aux_req, p_int_req} = '0;
    {host_req, host_exp, proc_req} = '0;
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_power_up();
    t_dev_to_peer();
    t_peer_to_dev();
    t_restore();
    t_fill();
    t_aux();
    t_bus();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
